// ===== design/pio_pkg.sv
package pio_pkg;
  localparam int PIO_DW = 16;
  localparam int PIO_SELW = 6;
  // The highest selector code belongs to the processor itself.
  localparam logic [5:0] PIO_CPU_CODE = 6'h3f;
  localparam logic [5:0] PIO_DEF_CODE = 6'h0b;
  localparam logic [5:0] PIO_DEF_MASK = 6'h3f;
  localparam logic [15:0] PIO_RST_WORD = 16'h0000;
  localparam logic [1:0] PIO_RST_FLAGS = 2'h0;
  // Least settle time of data before an output strobe, in ns.
  localparam int PIO_SETTLE_NS = 300;
  // Least strobe width, in ns.
  localparam int PIO_STROBE_NS = 500;
  localparam int PIO_CLK_NS = 100;
  localparam int PIO_SETTLE_CYC = (PIO_SETTLE_NS + PIO_CLK_NS - 1) / PIO_CLK_NS;
  localparam int PIO_STROBE_CYC = (PIO_STROBE_NS + PIO_CLK_NS - 1) / PIO_CLK_NS;
  localparam logic [3:0] PIO_CNT_RST = 4'h0;

  // Control field codes (instruction bits 8 and 9).
  localparam logic [1:0] PIO_CTL_NONE = 2'h0;
  localparam logic [1:0] PIO_CTL_START = 2'h1;
  localparam logic [1:0] PIO_CTL_CLEAR = 2'h2;
  localparam logic [1:0] PIO_CTL_PULSE = 2'h3;

  // Instruction kinds for the processor end.
  localparam logic [2:0] PIO_OP_IN = 3'h0;
  localparam logic [2:0] PIO_OP_OUT = 3'h1;
  localparam logic [2:0] PIO_OP_SKIP = 3'h2;
  localparam logic [2:0] PIO_OP_CTL = 3'h3;

  // Host-side APB register offsets.
  localparam logic [7:0] PIO_REG_CMD = 8'h00;
  localparam logic [7:0] PIO_REG_WDATA = 8'h04;
  localparam logic [7:0] PIO_REG_STATUS = 8'h08;
  localparam logic [7:0] PIO_REG_RDATA = 8'h0c;
  // Command word fields.
  localparam int PIO_CMD_SEL_LSB = 0;
  localparam int PIO_CMD_LET_LSB = 6;
  localparam int PIO_CMD_CTL_LSB = 8;
  localparam int PIO_CMD_OP_LSB = 10;
  localparam int PIO_CMD_TST_LSB = 13;
endpackage

// ===== design/pio_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pio_bus_if;
  logic [5:0] sel_n;
  logic [2:0] in_strobe;
  logic [2:0] out_strobe;
  logic start_pulse;
  logic clear_pulse;
  logic special_pulse;
  logic bus_reset;
  logic [15:0] cpu_data_o;
  logic cpu_data_oe_n;
  logic [15:0] dev_data_o;
  logic dev_data_oe_n;
  logic selected_busy_line_n;
  logic selected_done_line_n;
  logic [15:0] data;
  assign data = !dev_data_oe_n ? dev_data_o : (!cpu_data_oe_n ? cpu_data_o : 16'hffff);
  modport cpu (
    output sel_n, in_strobe, out_strobe, start_pulse, clear_pulse, special_pulse,
    output bus_reset, cpu_data_o, cpu_data_oe_n,
    input data, selected_busy_line_n, selected_done_line_n
  );
  modport dev (
    input sel_n, in_strobe, out_strobe, start_pulse, clear_pulse, special_pulse,
    input bus_reset, data,
    output dev_data_o, dev_data_oe_n, selected_busy_line_n, selected_done_line_n
  );
endinterface
`default_nettype wire

// ===== design/pio_dev.sv
// Summary of operation
// - Six-bit selector code addresses one peripheral.
// - Selection alone never drives data or acts.
// - Selector lines active low, first is msb.
// - Masked decode answers a group of codes.
// - Undecoded selector bits latched as mode.
// - Never answer the processor's reserved code.
// - Input strobe drives matching source word.
// - Processor samples data before dropping strobe.
// - Only selected device drives, only during input.
// - Transfer first, then at most one pulse.
// - Output strobe loads matching destination register.
// - Processor settles data before output strobe.
// - No device drives data during output.
// - Output registers independent of input sources.
// - Busy and done lines driven when selected.
// - Test field picks skip condition.
// - Bits 8-9 pick start, clear or special.
// - Start sets busy, clears done; clear clears.
// - Completion while busy clears busy and sets done.
// - Bus reset clears flags, destinations and mode, not the strobe stages.
`timescale 1ns/1ps
`default_nettype none
module pio_dev
  import pio_pkg::*;
#(
  parameter logic [5:0] DEV_CODE = PIO_DEF_CODE,
  parameter logic [5:0] DEV_MASK = PIO_DEF_MASK
) (
  input wire logic clk,
  input wire logic sys_rst,
  pio_bus_if.dev bus,
  input wire logic [15:0] src_a,
  input wire logic [15:0] src_b,
  input wire logic [15:0] src_c,
  input wire logic operation_finished,
  output logic [15:0] dest_a,
  output logic [15:0] dest_b,
  output logic [15:0] dest_c,
  output logic [5:0] mode,
  output logic busy,
  output logic done,
  output logic start_seen,
  output logic special_seen
);
  typedef struct packed {
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    logic [8:0] lvl;
    logic [15:0] da;
    logic [15:0] db;
    logic [15:0] dc;
    logic [5:0] mode;
    logic busy;
    logic done;
    logic st;
    logic sp;
  } pio_dev_st_t;

  pio_dev_st_t q, d;
  logic [5:0] code;
  logic hit;
  logic [8:0] rise;
  logic [2:0] ctl_rise;
  logic [2:0] in_rise;
  logic [2:0] out_rise;
  logic any_rise;

  function automatic logic pio_dev_match(input logic [5:0] c);
    pio_dev_match = ((c & DEV_MASK) == (DEV_CODE & DEV_MASK)) && (c != PIO_CPU_CODE);
  endfunction

  // Bits outside the mask name the mode.
  function automatic logic [5:0] pio_dev_group(input logic [5:0] c);
    pio_dev_group = c & ~DEV_MASK;
  endfunction

  // A level moves only once the second and third stages agree, so a glitch never counts.
  function automatic logic [8:0] pio_dev_agree(input logic [8:0] a, input logic [8:0] b,
    input logic [8:0] l);
    pio_dev_agree = (a & b) | (l & (a | b));
  endfunction

  // Invert lines, first line is msb.
  assign code = ~bus.sel_n;
  // The selector is steady well before and after every strobe, so it is decoded directly.
  assign hit = pio_dev_match(code);

  assign rise = q.s2 & q.s3 & ~q.lvl;
  assign ctl_rise = rise[2:0];
  assign in_rise = rise[5:3];
  assign out_rise = rise[8:6];
  assign any_rise = (|ctl_rise) || (|in_rise) || (|out_rise);

  always_comb begin
    d = q;
    d.s1 = {bus.out_strobe, bus.in_strobe, bus.special_pulse, bus.clear_pulse, bus.start_pulse};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = pio_dev_agree(q.s2, q.s3, q.lvl);
    d.st = 1'b0;
    d.sp = 1'b0;
    // Actions need selection and a strobe.
    if (hit) begin
      if (ctl_rise[1]) begin
        d.busy = 1'b0;
        d.done = 1'b0;
      end
      if (ctl_rise[0]) begin
        d.busy = 1'b1;
        d.done = 1'b0;
        d.st = 1'b1;
      end
      if (ctl_rise[2]) begin
        d.sp = 1'b1;
      end
      // Load matching destination.
      // Bus data has settled well before the strobe, so it is taken directly.
      if (out_rise[0]) begin
        d.da = bus.data;
      end
      if (out_rise[1]) begin
        d.db = bus.data;
      end
      if (out_rise[2]) begin
        d.dc = bus.data;
      end
      if (any_rise) begin
        d.mode = pio_dev_group(code);
      end
    end
    // Completion only counts while busy, so a job cleared in an earlier cycle never reports done.
    if (operation_finished && q.busy) begin
      d.busy = 1'b0;
      d.done = 1'b1;
    end
    if (bus.bus_reset) begin
      d.busy = PIO_RST_FLAGS[0];
      d.done = PIO_RST_FLAGS[1];
      d.st = 1'b0;
      d.sp = 1'b0;
      d.da = PIO_RST_WORD;
      d.db = PIO_RST_WORD;
      d.dc = PIO_RST_WORD;
      d.mode = 6'h00;
    end
  end

  // Strobe stages start low, matching the idle bus, so no false edge follows reset.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q.s1 <= 9'h000;
      q.s2 <= 9'h000;
      q.s3 <= 9'h000;
      q.lvl <= 9'h000;
      q.da <= PIO_RST_WORD;
      q.db <= PIO_RST_WORD;
      q.dc <= PIO_RST_WORD;
      q.mode <= 6'h00;
      q.busy <= PIO_RST_FLAGS[0];
      q.done <= PIO_RST_FLAGS[1];
      q.st <= 1'b0;
      q.sp <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Drive only on input strobe when selected.
  always_comb begin
    bus.dev_data_oe_n = 1'b1;
    bus.dev_data_o = 16'h0000;
    if (hit && (bus.out_strobe == 3'h0)) begin
      if (bus.in_strobe[0]) begin
        bus.dev_data_oe_n = 1'b0;
        bus.dev_data_o = src_a;
      end else if (bus.in_strobe[1]) begin
        bus.dev_data_oe_n = 1'b0;
        bus.dev_data_o = src_b;
      end else if (bus.in_strobe[2]) begin
        bus.dev_data_oe_n = 1'b0;
        bus.dev_data_o = src_c;
      end
    end
  end

  assign bus.selected_busy_line_n = !(hit && q.busy);
  assign bus.selected_done_line_n = !(hit && q.done);

  assign dest_a = q.da;
  assign dest_b = q.db;
  assign dest_c = q.dc;
  assign mode = q.mode;
  assign busy = q.busy;
  assign done = q.done;
  assign start_seen = q.st;
  assign special_seen = q.sp;
endmodule
`default_nettype wire

// ===== design/pio_cpu.sv
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pio_cpu
  import pio_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_reset_req,
  pio_bus_if.cpu bus
);
  typedef enum logic [5:0] {
    PIO_IDLE = 6'h01, PIO_SETUP = 6'h02, PIO_XFER = 6'h04,
    PIO_GAP = 6'h08, PIO_CTLP = 6'h10, PIO_END = 6'h20
  } pio_cpu_state_t;
  typedef struct packed {
    pio_cpu_state_t st;
    logic [15:0] cmd;
    logic [15:0] wd;
    logic [15:0] rd;
    logic skip;
    logic [3:0] cnt;
    logic [5:0] sel_n;
    logic [2:0] is;
    logic [2:0] os;
    logic [2:0] pul;
    logic doe_n;
    logic rst;
  } pio_cpu_reg_t;
  pio_cpu_reg_t q, d;
  logic wr, rd_ok;
  logic [2:0] op;
  logic [1:0] let_sel, ctl, tst;
  assign wr = psel && penable && pwrite;
  assign op = q.cmd[PIO_CMD_OP_LSB +: 3];
  assign let_sel = q.cmd[PIO_CMD_LET_LSB +: 2];
  assign ctl = q.cmd[PIO_CMD_CTL_LSB +: 2];
  assign tst = q.cmd[PIO_CMD_TST_LSB +: 2];
  assign rd_ok = (paddr == PIO_REG_CMD) || (paddr == PIO_REG_WDATA) ||
    (paddr == PIO_REG_STATUS) || (paddr == PIO_REG_RDATA);

  function automatic logic [2:0] pio_onehot(input logic [1:0] l);
    pio_onehot = (l == 2'h0) ? 3'h1 : ((l == 2'h1) ? 3'h2 : 3'h4);
  endfunction

  always_comb begin
    d = q;
    d.rst = 1'b0;
    unique case (q.st)
      PIO_IDLE: begin
        if (wr && paddr == PIO_REG_CMD) begin
          d.cmd = pwdata[15:0];
          d.sel_n = pwdata[15] ? 6'h3f : ~pwdata[5:0];
          d.rst = pwdata[15];
          d.st = pwdata[15] ? PIO_IDLE : PIO_SETUP;
          d.cnt = PIO_CNT_RST;
        end
        if (wr && paddr == PIO_REG_WDATA) begin
          d.wd = pwdata[15:0];
        end
      end
      PIO_SETUP: begin
        d.cnt = q.cnt + 4'h1;
        // Data settles before the output strobe.
        if (op == PIO_OP_OUT) begin
          d.doe_n = 1'b0;
        end
        if (q.cnt == 4'(PIO_SETTLE_CYC)) begin
          d.cnt = PIO_CNT_RST;
          d.st = PIO_XFER;
          if (op == PIO_OP_OUT) begin
            d.os = pio_onehot(let_sel);
          end
          if (op == PIO_OP_IN) begin
            d.is = pio_onehot(let_sel);
          end
        end
      end
      PIO_XFER: begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(PIO_STROBE_CYC)) begin
          d.rd = bus.data;
          unique case (tst)
            2'h0: d.skip = !bus.selected_busy_line_n;
            2'h1: d.skip = bus.selected_busy_line_n;
            2'h2: d.skip = !bus.selected_done_line_n;
            default: d.skip = bus.selected_done_line_n;
          endcase
          d.is = 3'h0;
          d.os = 3'h0;
          d.cnt = PIO_CNT_RST;
          d.st = PIO_GAP;
        end
      end
      PIO_GAP: begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(PIO_SETTLE_CYC)) begin
          d.doe_n = 1'b1;
          d.cnt = PIO_CNT_RST;
          d.st = PIO_CTLP;
          // One pulse after transfer, none for skip.
          if (op != PIO_OP_SKIP && ctl != PIO_CTL_NONE) begin
            d.pul = pio_onehot(ctl - 2'h1);
          end
        end
      end
      PIO_CTLP: begin
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(PIO_STROBE_CYC)) begin
          d.pul = 3'h0;
          d.cnt = PIO_CNT_RST;
          d.st = PIO_END;
        end
      end
      PIO_END: begin
        d.sel_n = 6'h3f;
        d.st = PIO_IDLE;
      end
      default: d.st = PIO_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= PIO_IDLE;
      q.sel_n <= 6'h3f;
      q.doe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      unique case (paddr)
        PIO_REG_CMD: prdata = {16'h0000, q.cmd};
        PIO_REG_WDATA: prdata = {16'h0000, q.wd};
        PIO_REG_STATUS: prdata = {30'h00000000, q.skip, q.st != PIO_IDLE};
        PIO_REG_RDATA: prdata = {16'h0000, q.rd};
        default: prdata = 32'h00000000;
      endcase
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_ok;
  assign bus.sel_n = q.sel_n;
  assign bus.in_strobe = q.is;
  assign bus.out_strobe = q.os;
  assign bus.start_pulse = q.pul[0];
  assign bus.clear_pulse = q.pul[1];
  assign bus.special_pulse = q.pul[2];
  assign bus.bus_reset = q.rst;
  assign bus.cpu_data_o = q.wd;
  assign bus.cpu_data_oe_n = q.doe_n;
  assign bus_reset_req = q.rst;
endmodule
`default_nettype wire

// ===== tb/pio_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pio_properties
  import pio_pkg::*;
#(
  parameter logic [5:0] DEV_CODE = PIO_DEF_CODE,
  parameter logic [5:0] DEV_MASK = PIO_DEF_MASK
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] sel_n,
  input wire logic [2:0] in_strobe,
  input wire logic [2:0] out_strobe,
  input wire logic start_pulse,
  input wire logic clear_pulse,
  input wire logic special_pulse,
  input wire logic cpu_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic selected_busy_line_n,
  input wire logic selected_done_line_n
);
  logic hit;
  // The processor's own code never selects us, even if the mask would match it.
  assign hit = ((~sel_n & DEV_MASK) == (DEV_CODE & DEV_MASK)) && (~sel_n != PIO_CPU_CODE);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_no_drive; !dev_data_oe_n |-> hit && (|in_strobe); endproperty
  a_no_drive: assert property (p_no_drive) else $error("data driven unasked");
  property p_in_drive; hit && (|in_strobe) |-> !dev_data_oe_n; endproperty
  a_in_drive: assert property (p_in_drive) else $error("input word not driven");
  property p_out_quiet; (|out_strobe) |-> dev_data_oe_n; endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("device drove on output");
  property p_reserved; sel_n == ~PIO_CPU_CODE |-> dev_data_oe_n && selected_busy_line_n; endproperty
  a_reserved: assert property (p_reserved) else $error("answered reserved code");
  property p_idle_lines; !hit |-> selected_busy_line_n && selected_done_line_n; endproperty
  a_idle_lines: assert property (p_idle_lines) else $error("status lines unselected");
  property p_start;
    $rose(start_pulse) && hit |-> ##[1:6] (!selected_busy_line_n && selected_done_line_n);
  endproperty
  a_start: assert property (p_start) else $error("start did not set busy");
  property p_clear;
    $rose(clear_pulse) && hit |-> ##[1:6] (selected_busy_line_n && selected_done_line_n);
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a flag");
  property p_settle; $rose(|out_strobe) |-> !$past(cpu_data_oe_n, 2); endproperty
  a_settle: assert property (p_settle) else $error("strobe before data settled");
  property p_hold; $fell(|out_strobe) |-> !cpu_data_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("data dropped before strobe");
  property p_pulse_after;
    start_pulse || clear_pulse || special_pulse |-> !(|in_strobe) && !(|out_strobe);
  endproperty
  a_pulse_after: assert property (p_pulse_after) else $error("pulse during transfer");
  property p_sel_held; (|in_strobe) || (|out_strobe) |-> $stable(sel_n); endproperty
  a_sel_held: assert property (p_sel_held) else $error("selector moved");
endmodule
`default_nettype wire

// ===== tb/test_programmed_io_bus_slave.sv
`timescale 1ns/1ps
`default_nettype none
module test_programmed_io_bus_slave
  import pio_pkg::*;
;
  localparam logic [5:0] CODE = 6'h38;
  localparam logic [5:0] MASK = 6'h38;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, chk = 1'b0, fin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, busy, done, start_seen, special_seen;
  logic [15:0] s[3] = '{16'h0, 16'h0, 16'h0};
  logic [15:0] v[3], dest_a, dest_b, dest_c;
  logic [5:0] mode;
  logic [5:0] bad[3] = '{6'h04, 6'h3f, 6'h0c};
  logic [32:0] exp_q[$], msk_q[$];
  int err_total = 0, n_compared = 0, cyc = 0, n_start = 0, n_special = 0;
  always #50 clk = ~clk;
  pio_bus_if pio_bus_if_i();
  pio_cpu pio_cpu_i(.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_reset_req(), .bus(pio_bus_if_i));
  pio_dev #(.DEV_CODE(CODE), .DEV_MASK(MASK)) pio_dev_i(.clk(clk), .sys_rst(sys_rst),
    .bus(pio_bus_if_i), .src_a(s[0]), .src_b(s[1]), .src_c(s[2]), .operation_finished(fin),
    .dest_a(dest_a), .dest_b(dest_b), .dest_c(dest_c), .mode(mode), .busy(busy),
    .done(done), .start_seen(start_seen), .special_seen(special_seen));
  pio_properties #(.DEV_CODE(CODE), .DEV_MASK(MASK)) pio_properties_i(.clk(clk),
    .sys_rst(sys_rst), .sel_n(pio_bus_if_i.sel_n), .in_strobe(pio_bus_if_i.in_strobe),
    .out_strobe(pio_bus_if_i.out_strobe), .start_pulse(pio_bus_if_i.start_pulse),
    .clear_pulse(pio_bus_if_i.clear_pulse), .special_pulse(pio_bus_if_i.special_pulse),
    .cpu_data_oe_n(pio_bus_if_i.cpu_data_oe_n), .dev_data_oe_n(pio_bus_if_i.dev_data_oe_n),
    .selected_busy_line_n(pio_bus_if_i.selected_busy_line_n),
    .selected_done_line_n(pio_bus_if_i.selected_done_line_n));
  task automatic compare(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk <= 1'b0;
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask
  // Polling keeps the command register from being written while it would refuse.
  task automatic run(input logic [31:0] c);
    apb(1'b1, PIO_REG_CMD, c, 1'b0);
    do apb(1'b0, PIO_REG_STATUS, 32'h0, 1'b0); while (rd[0] !== 1'b0);
  endtask
  function automatic logic [31:0] cw(logic [2:0] op, logic [1:0] ctl, logic [5:0] code,
    logic [1:0] lt, logic [1:0] tst);
    cw = 32'h0;
    cw[PIO_CMD_SEL_LSB +: 6] = code;
    cw[PIO_CMD_LET_LSB +: 2] = lt;
    cw[PIO_CMD_CTL_LSB +: 2] = ctl;
    cw[PIO_CMD_OP_LSB +: 3] = op;
    cw[PIO_CMD_TST_LSB +: 2] = tst;
  endfunction
  task automatic skips(input logic b, input logic d);
    for (int t = 0; t < 4; t++) begin
      run(cw(PIO_OP_SKIP, PIO_CTL_NONE, CODE | 6'h01, 2'h0, 2'(t)));
      expect_rd(PIO_REG_STATUS, 33'({t[1] ? d ^ t[0] : b ^ t[0], 1'b0}), 33'h100000002);
    end
    compare(33'({busy, done}), 33'({b, d})); // flag state
  endtask
  task automatic finish_op();
    @(posedge clk);
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && chk) begin
      compare({pslverr, prdata} & msk_q[0], exp_q[0]); // read result
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // A hang ends in the same report as a normal run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      wrap_up();
    end
  end
  // Counts of accepted start and special pulses at the device.
  always @(posedge clk) begin
    n_start <= n_start + (start_seen ? 1 : 0);
    n_special <= n_special + (special_seen ? 1 : 0);
  end
  initial begin
    void'($urandom(32'h5caa2eb0));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) s[i] <= 16'($urandom());
    @(negedge clk);
    compare(33'({dest_a, dest_b}), 33'h0); // reset state
    compare(33'({dest_c, mode, busy, done}), 33'h0); // reset state
    for (int i = 0; i < 3; i++) begin
      v[i] = 16'($urandom());
      apb(1'b1, PIO_REG_WDATA, {16'h0, v[i]}, 1'b0);
      run(cw(PIO_OP_OUT, PIO_CTL_NONE, CODE | 6'(i), 2'(i), 2'h0));
      compare(33'(mode), 33'(i)); // mode capture
    end
    compare(33'(dest_a), 33'(v[0])); // dest a
    compare(33'(dest_b), 33'(v[1])); // dest b
    compare(33'(dest_c), 33'(v[2])); // dest c
    for (int i = 0; i < 3; i++) begin
      run(cw(PIO_OP_IN, PIO_CTL_NONE, CODE | 6'(2 - i), 2'(i), 2'h0));
      expect_rd(PIO_REG_RDATA, 33'(s[i]), 33'h10000ffff); // word taken
      run(cw(PIO_OP_IN, PIO_CTL_NONE, bad[i], 2'(i), 2'h0));
      expect_rd(PIO_REG_RDATA, 33'h0ffff, 33'h10000ffff);
    end
    expect_rd(8'h10, 33'h100000000, 33'h100000000);
    run(cw(PIO_OP_IN, PIO_CTL_START, CODE, 2'h2, 2'h0));
    expect_rd(PIO_REG_RDATA, 33'(s[2]), 33'h10000ffff);
    skips(1'b1, 1'b0);
    finish_op();
    skips(1'b0, 1'b1);
    run(cw(PIO_OP_CTL, PIO_CTL_PULSE, CODE, 2'h0, 2'h0));
    compare(33'(n_special), 33'h1); // special pulse
    run(cw(PIO_OP_CTL, PIO_CTL_START, 6'h0c, 2'h0, 2'h0));
    skips(1'b0, 1'b1);
    run(cw(PIO_OP_OUT, PIO_CTL_START, CODE, 2'h1, 2'h0));
    run(cw(PIO_OP_CTL, PIO_CTL_CLEAR, CODE, 2'h0, 2'h0));
    finish_op();
    skips(1'b0, 1'b0);
    run(cw(PIO_OP_CTL, PIO_CTL_START, CODE | 6'h03, 2'h0, 2'h0));
    compare(33'(mode), 33'h3); // mode from pulse
    compare(33'(n_start), 33'h3); // selected starts
    run(32'h00008000);
    @(negedge clk);
    compare(33'({dest_a, dest_b}), 33'h0); // bus reset
    compare(33'({dest_c, mode, busy, done}), 33'h0); // bus reset
    wrap_up();
  end
endmodule
`default_nettype wire
